/* rtl/vcr_pkg.sv */
// package for the virtualization capability report bank
// assumes software reads the bank by 32-bit register index
package vcr_pkg;
   // register indices
   localparam logic [31:0] VCR_IDX_CZ_MUST = 32'h0000_0486;
   localparam logic [31:0] VCR_IDX_CZ_MAY = 32'h0000_0487;
   localparam logic [31:0] VCR_IDX_CF_MUST = 32'h0000_0488;
   localparam logic [31:0] VCR_IDX_CF_MAY = 32'h0000_0489;
   localparam logic [31:0] VCR_IDX_FLD_LIMIT = 32'h0000_048A;
   localparam logic [31:0] VCR_IDX_TT_CAP = 32'h0000_048C;
   localparam logic [31:0] VCR_IDX_FUNC_ALLOW = 32'h0000_0491;

   // field identifier layout
   localparam int VCR_FLD_RSVD_HI_LSB = 15;
   localparam int VCR_FLD_WIDTH_LSB = 13;
   localparam int VCR_FLD_RSVD_MID = 12;
   localparam int VCR_FLD_TYPE_LSB = 10;
   localparam int VCR_FLD_INDEX_LSB = 1;
   localparam int VCR_FLD_ACCESS_BIT = 0;

   // translation and tag capability bit positions
   localparam int VCR_CAP_XONLY = 0;
   localparam int VCR_CAP_WALK4 = 6;
   localparam int VCR_CAP_UC = 8;
   localparam int VCR_CAP_WB = 14;
   localparam int VCR_CAP_PG2M = 16;
   localparam int VCR_CAP_PG1G = 17;
   localparam int VCR_CAP_TINV = 20;
   localparam int VCR_CAP_AD = 21;
   localparam int VCR_CAP_ADV_INFO = 22;
   localparam int VCR_CAP_SSTK = 23;
   localparam int VCR_CAP_TINV_ONE = 25;
   localparam int VCR_CAP_TINV_ALL = 26;
   localparam int VCR_CAP_GINV = 32;
   localparam int VCR_CAP_GINV_ADDR = 40;
   localparam int VCR_CAP_GINV_ONE = 41;
   localparam int VCR_CAP_GINV_ALL = 42;
   localparam int VCR_CAP_GINV_KEEP = 43;
   localparam int VCR_CAP_PFX_LSB = 48;
   localparam logic [63:0] VCR_CAP_PFX_FIELD = 64'h3F;

   // bits that carry meaning; all others read as zero
   localparam logic [63:0] VCR_CAP_DEF_MASK =
      (64'h1 << VCR_CAP_XONLY) | (64'h1 << VCR_CAP_WALK4) |
      (64'h1 << VCR_CAP_UC) | (64'h1 << VCR_CAP_WB) |
      (64'h1 << VCR_CAP_PG2M) | (64'h1 << VCR_CAP_PG1G) |
      (64'h1 << VCR_CAP_TINV) | (64'h1 << VCR_CAP_AD) |
      (64'h1 << VCR_CAP_ADV_INFO) | (64'h1 << VCR_CAP_SSTK) |
      (64'h1 << VCR_CAP_TINV_ONE) | (64'h1 << VCR_CAP_TINV_ALL) |
      (64'h1 << VCR_CAP_GINV) | (64'h1 << VCR_CAP_GINV_ADDR) |
      (64'h1 << VCR_CAP_GINV_ONE) | (64'h1 << VCR_CAP_GINV_ALL) |
      (64'h1 << VCR_CAP_GINV_KEEP) | (VCR_CAP_PFX_FIELD << VCR_CAP_PFX_LSB);

   // bits of the primary and secondary allow registers
   localparam int VCR_PRIM_SEC_ACT = 63;
   localparam int VCR_SEC_SLT = 33;
   localparam int VCR_SEC_TAG = 37;
   localparam int VCR_SEC_FUNC = 45;

   // implementation constants, plain defaults
   localparam logic [63:0] VCR_CZ_MUST_DEF = 64'h0000_0000_0000_0021;
   localparam logic [63:0] VCR_CZ_MAY_DEF = 64'h0000_0000_FFFF_FFFF;
   localparam logic [63:0] VCR_CF_MUST_DEF = 64'h0000_0000_0000_2000;
   localparam logic [63:0] VCR_CF_MAY_DEF = 64'h0000_0000_003F_FFFF;
   localparam logic [8:0] VCR_FLD_LIMIT_DEF = 9'h01A;
   localparam logic [63:0] VCR_TT_CAP_DEF = 64'h0001_0F01_0673_4141;
   localparam logic [63:0] VCR_FUNC_ALLOW_DEF = 64'h0000_0000_0000_0001;

   // reset value of every flop in the bank
   localparam logic [63:0] VCR_RST_WORD = 64'h0;
endpackage

/* rtl/vcr_field_dec.sv */
// splits a guest control block field identifier into its parts
// assumes a 32-bit identifier and a 9-bit highest index from the bank
module vcr_field_dec (
   input wire logic [31:0] i_enc,
   input wire logic [8:0] i_limit,
   output logic [1:0] o_width,
   output logic [1:0] o_type,
   output logic [8:0] o_index,
   output logic o_high,
   output logic o_ok
);
   import vcr_pkg::*;

   logic rsvd_clear;

   always_comb begin
      o_width = i_enc[VCR_FLD_WIDTH_LSB +: 2];
      o_type = i_enc[VCR_FLD_TYPE_LSB +: 2];
      o_index = i_enc[VCR_FLD_INDEX_LSB +: 9];
      o_high = i_enc[VCR_FLD_ACCESS_BIT];
      rsvd_clear = (i_enc[31:VCR_FLD_RSVD_HI_LSB] == 17'h0) &&
                   !i_enc[VCR_FLD_RSVD_MID];
      o_ok = rsvd_clear && (o_index <= i_limit);
   end
endmodule

/* rtl/vcr_regs.sv */
// read-only capability bank reporting virtualization constraints
// assumes reads and writes by register index, one clock, sync reset
//
// Notes on behaviour
// - must-be-one mask bits force control register zero bits high when active.
// - may-be-one mask zeros force control register zero bits low when active.
// - zero-register masks consistent: must-be-one bits also set in may-be-one.
// - control register four bits forced by its two masks while active.
// - control register four masks consistent in the same way.
// - field identifier: width 14:13, type 11:10, index 9:1, access bit 0.
// - field index limit gives highest index in 9:1, other bits zero.
// - capability bit 0 reports execute-only translations.
// - capability bit 6 reports four-level page walk.
// - bits 8 and 14 report uncacheable and write-back structure types.
// - bits 16 and 17 report 2-Mbyte and 1-Gbyte mappings.
// - bits 20, 25, 26 report translation invalidate and its types.
// - bits 21, 22, 23 report dirty flags, exit info, shadow-stack control.
// - bit 32 and bits 40-43 report tag invalidate and its types.
// - bits 53:48 give maximum hypervisor linear translation prefix size.
// - reserved capability bits always read as zero.
// - capability register exists only with secondary activate and slt or tag.
// - entry fails when a disallowed function bit is set and both enables on.
// - function allow register exists only with secondary activate and bit 45.
module vcr_regs #(
   parameter logic [63:0] P_CZ_MUST = vcr_pkg::VCR_CZ_MUST_DEF,
   parameter logic [63:0] P_CZ_MAY = vcr_pkg::VCR_CZ_MAY_DEF,
   parameter logic [63:0] P_CF_MUST = vcr_pkg::VCR_CF_MUST_DEF,
   parameter logic [63:0] P_CF_MAY = vcr_pkg::VCR_CF_MAY_DEF,
   parameter logic [8:0] P_FLD_LIMIT = vcr_pkg::VCR_FLD_LIMIT_DEF,
   parameter logic [63:0] P_TT_CAP = vcr_pkg::VCR_TT_CAP_DEF,
   parameter logic [63:0] P_FUNC_ALLOW = vcr_pkg::VCR_FUNC_ALLOW_DEF
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_rd_en,
   input wire logic [31:0] i_rd_index,
   output logic o_rd_valid,
   output logic [63:0] o_rd_data,
   output logic o_rd_fault,
   input wire logic i_wr_en,
   input wire logic [31:0] i_wr_index,
   output logic o_wr_fault,
   input wire logic [63:0] i_primary_allow,
   input wire logic [63:0] i_secondary_allow,
   input wire logic i_virt_active,
   input wire logic i_ctl0_wr_en,
   input wire logic [63:0] i_ctl0_wr_data,
   output logic [63:0] o_ctl0,
   input wire logic i_ctl4_wr_en,
   input wire logic [63:0] i_ctl4_wr_data,
   output logic [63:0] o_ctl4,
   input wire logic [31:0] i_fld_enc,
   output logic [1:0] o_fld_width,
   output logic [1:0] o_fld_type,
   output logic [8:0] o_fld_index,
   output logic o_fld_high,
   output logic o_fld_ok,
   input wire logic i_entry_req,
   input wire logic [63:0] i_func_ctrl,
   input wire logic i_sec_activate,
   input wire logic i_func_enable,
   output logic o_entry_done,
   output logic o_entry_fail
);
   import vcr_pkg::*;

   // may-be-one masks always cover the must-be-one masks
   localparam logic [63:0] CZ_MAY = P_CZ_MAY | P_CZ_MUST;
   localparam logic [63:0] CF_MAY = P_CF_MAY | P_CF_MUST;
   localparam logic [63:0] LIMIT_WORD = {54'h0, P_FLD_LIMIT, 1'b0};
   localparam logic [63:0] TT_CAP = P_TT_CAP & VCR_CAP_DEF_MASK;

   logic rd_valid_q;
   logic [63:0] rd_data_q;
   logic rd_fault_q;
   logic wr_fault_q;
   logic [63:0] ctl0_q;
   logic [63:0] ctl4_q;
   logic [1:0] fld_width_q;
   logic [1:0] fld_type_q;
   logic [8:0] fld_index_q;
   logic fld_high_q;
   logic fld_ok_q;
   logic entry_done_q;
   logic entry_fail_q;
   logic cap_exists;
   logic func_exists;
   logic rd_hit;
   logic [63:0] rd_word;
   logic [1:0] dec_width;
   logic [1:0] dec_type;
   logic [8:0] dec_index;
   logic dec_high;
   logic dec_ok;
   logic func_bad;

   // apply a must-be-one / may-be-one mask pair to a value
   function automatic logic [63:0] fix_bits(input logic [63:0] v,
                                            input logic [63:0] must,
                                            input logic [63:0] may);
      return (v | must) & may;
   endfunction

   assign cap_exists = i_primary_allow[VCR_PRIM_SEC_ACT] &&
      (i_secondary_allow[VCR_SEC_SLT] || i_secondary_allow[VCR_SEC_TAG]);
   assign func_exists = i_primary_allow[VCR_PRIM_SEC_ACT] &&
      i_secondary_allow[VCR_SEC_FUNC];

   // read decode; absent or unknown indices fault
   always_comb begin
      rd_hit = 1'b1;
      rd_word = VCR_RST_WORD;
      case (i_rd_index)
         VCR_IDX_CZ_MUST: rd_word = P_CZ_MUST;
         VCR_IDX_CZ_MAY: rd_word = CZ_MAY;
         VCR_IDX_CF_MUST: rd_word = P_CF_MUST;
         VCR_IDX_CF_MAY: rd_word = CF_MAY;
         VCR_IDX_FLD_LIMIT: rd_word = LIMIT_WORD;
         VCR_IDX_TT_CAP: begin
            rd_hit = cap_exists;
            rd_word = cap_exists ? TT_CAP : VCR_RST_WORD;
         end
         VCR_IDX_FUNC_ALLOW: begin
            rd_hit = func_exists;
            rd_word = func_exists ? P_FUNC_ALLOW : VCR_RST_WORD;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= VCR_RST_WORD;
         rd_fault_q <= 1'b0;
      end else begin
         rd_valid_q <= i_rd_en && rd_hit;
         rd_data_q <= (i_rd_en && rd_hit) ? rd_word : VCR_RST_WORD;
         rd_fault_q <= i_rd_en && !rd_hit;
      end
   end

   // every write is refused; contents are constants
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_fault_q <= 1'b0;
      end else begin
         wr_fault_q <= i_wr_en;
      end
   end

   // control register zero, pinned while virtualization is active
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctl0_q <= VCR_RST_WORD;
      end else if (i_ctl0_wr_en) begin
         ctl0_q <= i_virt_active ?
            fix_bits(i_ctl0_wr_data, P_CZ_MUST, CZ_MAY) : i_ctl0_wr_data;
      end else if (i_virt_active) begin
         ctl0_q <= fix_bits(ctl0_q, P_CZ_MUST, CZ_MAY);
      end
   end

   // control register four, same treatment
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctl4_q <= VCR_RST_WORD;
      end else if (i_ctl4_wr_en) begin
         ctl4_q <= i_virt_active ?
            fix_bits(i_ctl4_wr_data, P_CF_MUST, CF_MAY) : i_ctl4_wr_data;
      end else if (i_virt_active) begin
         ctl4_q <= fix_bits(ctl4_q, P_CF_MUST, CF_MAY);
      end
   end

   vcr_field_dec u_dec (
      .i_enc(i_fld_enc),
      .i_limit(P_FLD_LIMIT),
      .o_width(dec_width),
      .o_type(dec_type),
      .o_index(dec_index),
      .o_high(dec_high),
      .o_ok(dec_ok)
   );

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fld_width_q <= 2'h0;
         fld_type_q <= 2'h0;
         fld_index_q <= 9'h000;
         fld_high_q <= 1'b0;
         fld_ok_q <= 1'b0;
      end else begin
         fld_width_q <= dec_width;
         fld_type_q <= dec_type;
         fld_index_q <= dec_index;
         fld_high_q <= dec_high;
         fld_ok_q <= dec_ok;
      end
   end

   // entry check on the function controls
   assign func_bad = |(i_func_ctrl & ~P_FUNC_ALLOW);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         entry_done_q <= 1'b0;
         entry_fail_q <= 1'b0;
      end else begin
         entry_done_q <= i_entry_req;
         entry_fail_q <= i_entry_req && func_bad &&
                         i_sec_activate && i_func_enable;
      end
   end

   assign o_rd_valid = rd_valid_q;
   assign o_rd_data = rd_data_q;
   assign o_rd_fault = rd_fault_q;
   assign o_wr_fault = wr_fault_q;
   assign o_ctl0 = ctl0_q;
   assign o_ctl4 = ctl4_q;
   assign o_fld_width = fld_width_q;
   assign o_fld_type = fld_type_q;
   assign o_fld_index = fld_index_q;
   assign o_fld_high = fld_high_q;
   assign o_fld_ok = fld_ok_q;
   assign o_entry_done = entry_done_q;
   assign o_entry_fail = entry_fail_q;

   default clocking dcb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   AST_CTL0_ONES: assert property (
      i_virt_active |=> ((o_ctl0 & P_CZ_MUST) == P_CZ_MUST))
      else $error("ctl0 must-be-one bit low while active");

   AST_CTL0_ZEROS: assert property (
      i_virt_active |=> ((o_ctl0 & ~CZ_MAY) == 64'h0))
      else $error("ctl0 fixed-zero bit high while active");

   AST_CZ_CONSIST: assert property (
      (i_rd_en && i_rd_index == VCR_IDX_CZ_MAY) |=>
         o_rd_valid && ((o_rd_data & P_CZ_MUST) == P_CZ_MUST))
      else $error("zero-register masks inconsistent");

   AST_CTL4_FIXED: assert property (
      i_virt_active |=> ((o_ctl4 & P_CF_MUST) == P_CF_MUST) &&
                        ((o_ctl4 & ~CF_MAY) == 64'h0))
      else $error("ctl4 fixed bit violated while active");

   AST_CF_CONSIST: assert property (
      (i_rd_en && i_rd_index == VCR_IDX_CF_MAY) |=>
         o_rd_valid && ((o_rd_data & P_CF_MUST) == P_CF_MUST))
      else $error("four-register masks inconsistent");

   AST_FLD_SPLIT: assert property (
      ##1 (o_fld_index == $past(i_fld_enc[9:1])) &&
          (o_fld_width == $past(i_fld_enc[14:13])) &&
          (o_fld_ok -> $past(i_fld_enc[31:15] == 17'h0 && !i_fld_enc[12])))
      else $error("field identifier split wrong");

   AST_LIMIT_READ: assert property (
      (i_rd_en && i_rd_index == VCR_IDX_FLD_LIMIT) |=>
         o_rd_data[9:1] == P_FLD_LIMIT && o_rd_data[0] == 1'b0 &&
         o_rd_data[63:10] == 54'h0)
      else $error("field index limit read wrong");

   AST_CAP_RSVD: assert property (
      (i_rd_en && i_rd_index == VCR_IDX_TT_CAP) |=>
         ((o_rd_data & ~VCR_CAP_DEF_MASK) == 64'h0))
      else $error("reserved capability bit set");

   AST_CAP_ABSENT: assert property (
      (i_rd_en && i_rd_index == VCR_IDX_TT_CAP && !cap_exists) |=>
         o_rd_fault && !o_rd_valid)
      else $error("absent capability register answered");

   AST_ENTRY_FAIL: assert property (
      (i_entry_req && i_sec_activate && i_func_enable &&
       (|(i_func_ctrl & ~P_FUNC_ALLOW))) |=> o_entry_done && o_entry_fail)
      else $error("disallowed function entry not failed");

   AST_FUNC_ABSENT: assert property (
      (i_rd_en && i_rd_index == VCR_IDX_FUNC_ALLOW &&
       !i_secondary_allow[VCR_SEC_FUNC]) |=> o_rd_fault)
      else $error("absent function allow register answered");

   AST_WR_IGNORED: assert property (
      (i_wr_en && i_rd_en && i_rd_index == VCR_IDX_CZ_MUST) |=>
         o_wr_fault && o_rd_data == P_CZ_MUST)
      else $error("write altered bank or not refused");

   COV_CAP_READ: cover property (
      i_rd_en && i_rd_index == VCR_IDX_TT_CAP ##1 o_rd_valid);
   COV_ENTRY_FAIL: cover property (##1 o_entry_fail);
   COV_FLD_OK: cover property (##1 o_fld_ok && o_fld_high);
   COV_WR_REFUSED: cover property (##1 o_wr_fault);
endmodule

/* verification/vcr_regs_tb_top.sv */
// self-checking bench for the capability report bank
// assumes the bank answers reads, writes, decode and entry checks one cycle later
module vcr_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import vcr_pkg::*;

   logic i_clk;
   logic i_rst;
   logic i_rd_en;
   logic [31:0] i_rd_index;
   logic o_rd_valid;
   logic [63:0] o_rd_data;
   logic o_rd_fault;
   logic i_wr_en;
   logic [31:0] i_wr_index;
   logic o_wr_fault;
   logic [63:0] i_primary_allow;
   logic [63:0] i_secondary_allow;
   logic i_virt_active;
   logic i_ctl0_wr_en;
   logic [63:0] i_ctl0_wr_data;
   logic [63:0] o_ctl0;
   logic i_ctl4_wr_en;
   logic [63:0] i_ctl4_wr_data;
   logic [63:0] o_ctl4;
   logic [31:0] i_fld_enc;
   logic [1:0] o_fld_width;
   logic [1:0] o_fld_type;
   logic [8:0] o_fld_index;
   logic o_fld_high;
   logic o_fld_ok;
   logic i_entry_req;
   logic [63:0] i_func_ctrl;
   logic i_sec_activate;
   logic i_func_enable;
   logic o_entry_done;
   logic o_entry_fail;
   int failures;
   int cmp_count;
   logic [63:0] c0_exp;
   logic [63:0] c4_exp;
   logic [63:0] m_word;
   logic [31:0] enc;
   logic [14:0] fexp;
   // mapped indices first, then unmapped neighbours
   localparam logic [31:0] IDX_TAB [9] = '{32'h486, 32'h487, 32'h488, 32'h489, 32'h48A,
      32'h48C, 32'h491, 32'h48B, 32'h485};

   vcr_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_rd_en(i_rd_en), .i_rd_index(i_rd_index),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_fault(o_rd_fault),
      .i_wr_en(i_wr_en), .i_wr_index(i_wr_index), .o_wr_fault(o_wr_fault),
      .i_primary_allow(i_primary_allow), .i_secondary_allow(i_secondary_allow),
      .i_virt_active(i_virt_active), .i_ctl0_wr_en(i_ctl0_wr_en),
      .i_ctl0_wr_data(i_ctl0_wr_data), .o_ctl0(o_ctl0), .i_ctl4_wr_en(i_ctl4_wr_en),
      .i_ctl4_wr_data(i_ctl4_wr_data), .o_ctl4(o_ctl4), .i_fld_enc(i_fld_enc),
      .o_fld_width(o_fld_width), .o_fld_type(o_fld_type), .o_fld_index(o_fld_index),
      .o_fld_high(o_fld_high), .o_fld_ok(o_fld_ok), .i_entry_req(i_entry_req),
      .i_func_ctrl(i_func_ctrl), .i_sec_activate(i_sec_activate),
      .i_func_enable(i_func_enable), .o_entry_done(o_entry_done), .o_entry_fail(o_entry_fail));

   initial i_clk = 1'b0;
   always #20 i_clk = ~i_clk;

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [65:0] got, input logic [65:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // expected {valid, fault, data} of a read under the current allow inputs
   function automatic logic [65:0] exp_rd(input logic [31:0] idx);
      logic pr;
      logic [63:0] s;
      pr = i_primary_allow[VCR_PRIM_SEC_ACT];
      s = i_secondary_allow;
      case (idx)
         VCR_IDX_CZ_MUST: return {2'b10, VCR_CZ_MUST_DEF};
         VCR_IDX_CZ_MAY: return {2'b10, VCR_CZ_MAY_DEF | VCR_CZ_MUST_DEF};
         VCR_IDX_CF_MUST: return {2'b10, VCR_CF_MUST_DEF};
         VCR_IDX_CF_MAY: return {2'b10, VCR_CF_MAY_DEF | VCR_CF_MUST_DEF};
         VCR_IDX_FLD_LIMIT: return {2'b10, 54'h0, VCR_FLD_LIMIT_DEF, 1'b0};
         VCR_IDX_TT_CAP: begin
            if (pr && (s[VCR_SEC_SLT] || s[VCR_SEC_TAG])) begin
               return {2'b10, VCR_TT_CAP_DEF & VCR_CAP_DEF_MASK};
            end
         end
         VCR_IDX_FUNC_ALLOW: begin
            if (pr && s[VCR_SEC_FUNC]) begin
               return {2'b10, VCR_FUNC_ALLOW_DEF};
            end
         end
         default: ;
      endcase
      return {2'b01, 64'h0};
   endfunction

   // read stays requested; caller lowers i_rd_en after a burst
   task automatic rd(input logic [31:0] idx);
      logic [65:0] e;
      e = exp_rd(idx);
      i_rd_en = 1'b1;
      i_rd_index = idx;
      @(negedge i_clk);
      chk({o_rd_valid, o_rd_fault, o_rd_data}, e, "read answer");
   endtask

   initial begin
      repeat (5000) @(posedge i_clk);
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end

   initial begin
      failures = 0;
      cmp_count = 0;
      i_rst = 1'b1;
      {i_rd_en, i_wr_en, i_virt_active, i_ctl0_wr_en, i_ctl4_wr_en} = 5'h00;
      {i_entry_req, i_sec_activate, i_func_enable} = 3'h0;
      i_rd_index = 32'h0;
      i_wr_index = 32'h0;
      i_primary_allow = 64'h0;
      i_secondary_allow = 64'h0;
      i_ctl0_wr_data = 64'h0;
      i_ctl4_wr_data = 64'h0;
      i_fld_enc = 32'h0;
      i_func_ctrl = 64'h0;
      void'($urandom(84));
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      chk({o_rd_valid, o_rd_fault, o_ctl0 | o_ctl4}, 66'h0, "reset state");
      chk({o_rd_data, o_wr_fault, o_entry_done | o_entry_fail}, 66'h0, "reset state");
      i_primary_allow = {1'b1, 63'($urandom())};
      i_secondary_allow = {$urandom(), $urandom()} | 64'h0000_2022_0000_0000;
      for (int i = 0; i < 9; i++) rd(IDX_TAB[i]);
      rd(VCR_IDX_TT_CAP);
      chk({2'b00, o_rd_data & ~VCR_CAP_DEF_MASK}, 66'h0, "reserved cap bits");
      for (int p = 0; p < 2; p++) begin
         rd(IDX_TAB[2 * p]);
         m_word = o_rd_data;
         rd(IDX_TAB[2 * p + 1]);
         chk({2'b00, m_word & ~o_rd_data}, 66'h0, "mask pair consistency");
      end
      for (int k = 0; k < 16; k++) begin
         i_primary_allow = {k[3], 63'($urandom())};
         i_secondary_allow = {$urandom(), $urandom()};
         i_secondary_allow[VCR_SEC_SLT] = k[2];
         i_secondary_allow[VCR_SEC_TAG] = k[1];
         i_secondary_allow[VCR_SEC_FUNC] = k[0];
         rd(VCR_IDX_TT_CAP);
         rd(VCR_IDX_FUNC_ALLOW);
      end
      i_rd_en = 1'b0;
      @(negedge i_clk);
      chk({o_rd_valid, o_rd_fault, o_rd_data}, 66'h0, "read idle");
      i_wr_en = 1'b1;
      for (int i = 0; i < 7; i++) begin
         i_wr_index = (i < 6) ? IDX_TAB[i] : $urandom();
         // a read in the same cycle shows the write left the contents alone
         rd(IDX_TAB[i]);
         chk({65'h0, o_wr_fault}, 66'h1, "write refused");
      end
      i_wr_en = 1'b0;
      i_primary_allow = 64'h8000_0000_0000_0000;
      i_secondary_allow = 64'h0000_2022_0000_0000;
      for (int i = 0; i < 7; i++) rd(IDX_TAB[i]);
      i_rd_en = 1'b0;
      c0_exp = 64'h0;
      c4_exp = 64'h0;
      for (int i = 0; i < 40; i++) begin
         i_virt_active = (i < 4) ? i[1] : 1'($urandom());
         i_ctl0_wr_en = (i < 4) ? 1'b1 : 1'($urandom());
         i_ctl4_wr_en = (i < 4) ? 1'b1 : 1'($urandom());
         i_ctl0_wr_data = (i < 2) ? 64'h0 : {$urandom(), $urandom()};
         i_ctl4_wr_data = (i == 1) ? 64'h0 : {$urandom(), $urandom()};
         if (i_ctl0_wr_en) c0_exp = i_ctl0_wr_data;
         if (i_ctl4_wr_en) c4_exp = i_ctl4_wr_data;
         if (i_virt_active) c0_exp = (c0_exp | VCR_CZ_MUST_DEF) & VCR_CZ_MAY_DEF;
         if (i_virt_active) c4_exp = (c4_exp | VCR_CF_MUST_DEF) & VCR_CF_MAY_DEF;
         @(negedge i_clk);
         chk({2'b00, o_ctl0}, {2'b00, c0_exp}, "control zero");
         chk({2'b00, o_ctl4}, {2'b00, c4_exp}, "control four");
      end
      for (int i = 0; i < 40; i++) begin
         enc = $urandom();
         if (i % 2 == 0) enc = enc & 32'h0000_6FFF;
         if (i % 4 == 0) enc[9:1] = VCR_FLD_LIMIT_DEF + 9'(i % 8 / 4);
         i_fld_enc = enc;
         fexp = {enc[14:13], enc[11:10], enc[9:1], enc[0],
            enc[31:15] == 17'h0 && !enc[12] && enc[9:1] <= VCR_FLD_LIMIT_DEF};
         @(negedge i_clk);
         chk({51'h0, o_fld_width, o_fld_type, o_fld_index, o_fld_high, o_fld_ok},
            {51'h0, fexp}, "field decode");
      end
      i_entry_req = 1'b1;
      for (int i = 0; i < 32; i++) begin
         i_func_ctrl = {$urandom(), $urandom()};
         if (i % 2 == 0) i_func_ctrl = i_func_ctrl & VCR_FUNC_ALLOW_DEF;
         i_sec_activate = (i < 8) ? i[2] : 1'($urandom());
         i_func_enable = (i < 8) ? i[1] : 1'($urandom());
         m_word = i_func_ctrl & ~VCR_FUNC_ALLOW_DEF;
         @(negedge i_clk);
         chk({64'h0, o_entry_done, o_entry_fail},
            {64'h0, 1'b1, i_sec_activate & i_func_enable & (|m_word)}, "entry check");
      end
      i_entry_req = 1'b0;
      @(negedge i_clk);
      chk({64'h0, o_entry_done, o_entry_fail}, 66'h0, "entry idle");
      final_report();
   end
endmodule
